// >>> tb/esc_host_model.sv
// Host microcontroller model: drives the reset pin and the register port.
// Assumes the block samples every input on the rising edge of clk.
`timescale 1ns/1ns
module esc_host_model (
  input  wire logic        clk,
  input  wire logic [15:0] reg_rdata,
  output logic             rst_pin_n,
  output logic [3:0]       reg_addr,
  output logic [15:0]      reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd
);
  initial begin
    rst_pin_n = 1'b0;
    reg_addr  = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  task automatic bus_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic bus_rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // pin level change, callers hold low for 12 cycles.
  task automatic pin_set(input logic v);
    @(posedge clk);
    rst_pin_n <= v;
  endtask
endmodule

// >>> tb/esc_reset_ctl_tb.sv
// Self-checking bench for the configuration and reset sequencer.
// Assumes short OSC and TIMER counts so a full boot takes a few hundred cycles.
`timescale 1ns/1ns
`include "esc_defines.svh"
module esc_reset_ctl_tb;
  localparam int OSC = 20;
  localparam int TMR = 200;
  logic        clk, sys_rst, asym_ok, howl_trip;
  logic [7:0]  rx_pwr, tx_pwr, erle, noise;
  logic        rst_pin_n, reg_wr, reg_rd;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, d;
  logic        osc_en, blocks_pwr_en, clocks_run, calib_start, cold_rst, warm_rst;
  logic        coef_clear, full_duplex_ok, rx_suppress, tx_speech, path_sens_low;
  logic [7:0]  tx_att_db, tx_bias_db, tx_thr_db;
  logic        pc, pw, pcc;
  int          err_total, compares, cyc, rise, n;

  esc_host_model host (.clk(clk), .reg_rdata(reg_rdata), .rst_pin_n(rst_pin_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));

  esc_reset_ctl #(.OSC_CYC(OSC), .TIMER_CYC(TMR), .RAMP_CYC(8)) DUT (
    .clk(clk), .sys_rst(sys_rst), .rst_pin_n(rst_pin_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_pwr(rx_pwr), .tx_pwr(tx_pwr), .aec_erle_db(erle), .near_noise_db(noise),
    .asym_ok(asym_ok), .howl_trip(howl_trip), .osc_en(osc_en),
    .blocks_pwr_en(blocks_pwr_en), .clocks_run(clocks_run), .calib_start(calib_start),
    .cold_rst(cold_rst), .warm_rst(warm_rst), .coef_clear(coef_clear),
    .full_duplex_ok(full_duplex_ok), .rx_suppress(rx_suppress), .tx_speech(tx_speech),
    .path_sens_low(path_sens_low), .tx_att_db(tx_att_db), .tx_bias_db(tx_bias_db),
    .tx_thr_db(tx_thr_db));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) cyc <= cyc + 1;

  task automatic chk_bit(input logic g, input logic e, input string s);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("Error %0t: %s got %b exp %b", $time, s, g, e);
    end
  endtask

  task automatic chk_val(input logic [15:0] g, input logic [15:0] e, input string s);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("Error %0t: %s got %h exp %h", $time, s, g, e);
    end
  endtask

  task automatic chk_rng(input int g, input int lo, input int hi, input string s);
    compares++;
    if (g < lo || g > hi) begin
      err_total++;
      $display("Error %0t: %s count %0d not in %0d..%0d", $time, s, g, lo, hi);
    end
  endtask

  task automatic wait_rst(input int lim, output int k);
    pc = 1'bx;
    pw = 1'bx;
    pcc = 1'bx;
    k = 0;
    for (int i = 1; i <= lim && k == 0; i++) begin
      @(posedge clk);
      #1;
      if (cold_rst === 1'b1 || warm_rst === 1'b1) begin
        k = i;
        pc = cold_rst;
        pw = warm_rst;
        pcc = coef_clear;
      end
    end
  endtask

  task automatic boot_start();
    host.pin_set(1'b0);
    repeat (12) @(posedge clk);
    #1;
    chk_bit(osc_en, 1'b0, "osc stopped");
    chk_bit(blocks_pwr_en, 1'b0, "blocks down");
    host.pin_set(1'b1);
    rise = cyc;
    for (n = 0; n < 6 && osc_en !== 1'b1; n++) @(posedge clk);
    #1;
    chk_bit(osc_en, 1'b1, "osc started");
  endtask

  task automatic wait_clocks();
    for (n = 0; n < OSC + 6 && clocks_run !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    chk_rng(cyc - rise, OSC, OSC + 5, "clock start delay");
    chk_bit(calib_start, 1'b1, "calibration start");
  endtask

  task automatic cfg3(input logic [15:0] w);
    host.bus_wr(4'h0, w);
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic set_in(input logic [7:0] e, input logic [7:0] z, input logic a);
    @(posedge clk);
    erle <= e;
    noise <= z;
    asym_ok <= a;
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic t_defaults();
    chk_val({8'h00, tx_att_db}, 16'h0012, "att default");
    chk_val({8'h00, tx_bias_db}, 16'h0012, "bias default");
    chk_val({8'h00, tx_thr_db}, 16'h000F, "thr default");
    chk_bit(path_sens_low, 1'b0, "sens default");
  endtask

  task automatic t_cold();
    boot_start();
    host.bus_wr(4'h0, `ESC_WORD_WARM_X);
    wait_clocks();
    wait_rst(TMR + 20, n);
    chk_rng(cyc - rise, TMR - 10, TMR + 10, "timer length");
    chk_bit(pc, 1'b1, "cold chosen");
    chk_bit(pcc, 1'b1, "coefficients cleared");
    host.bus_rd(4'h0, d);
    chk_val(d, `ESC_MCR_RST, "mode word restored");
  endtask

  task automatic t_config();
    logic [7:0] att[3] = '{`ESC_DB_18, `ESC_DB_12, `ESC_DB_24};
    logic [7:0] bia[3] = '{`ESC_DB_18, `ESC_DB_15, `ESC_DB_21};
    logic [7:0] thr[3] = '{`ESC_DB_15, `ESC_DB_12, `ESC_DB_9};
    for (int c = 0; c < 3; c++) begin
      cfg3({6'h00, c[1:0], c[1:0], c[1:0], 1'b0, 3'b110});
      chk_val({8'h00, tx_att_db}, {8'h00, att[c]}, "attenuation");
      chk_val({8'h00, tx_bias_db}, {8'h00, bia[c]}, "bias");
      chk_val({8'h00, tx_thr_db}, {8'h00, thr[c]}, "threshold");
    end
    cfg3({6'h00, 2'b01, 4'h0, 1'b0, 3'b010});
    chk_val({8'h00, tx_att_db}, {8'h00, `ESC_DB_24}, "other select");
    cfg3({12'h000, 1'b1, 3'b100});
    chk_bit(path_sens_low, 1'b1, "low sensitivity");
    cfg3({12'h000, 1'b0, 3'b100});
    chk_bit(path_sens_low, 1'b0, "high sensitivity");
    host.bus_rd(4'h1, d);
    chk_val({14'h0000, d[1:0]}, 16'h0003, "status clocks");
    host.bus_rd(4'h9, d);
    chk_val(d, 16'h0000, "unmapped read");
  endtask

  task automatic t_duplex();
    logic [7:0] thr[3] = '{`ESC_DB_24, `ESC_DB_18, `ESC_DB_30};
    for (int c = 0; c < 3; c++) begin
      set_in(thr[c], 8'h00, 1'b0);
      cfg3({c[1:0], 2'b00, 8'h00, 1'b0, 3'b110});
      chk_bit(full_duplex_ok, 1'b0, "at threshold");
      set_in(thr[c] + 8'h01, 8'h00, 1'b0);
      chk_bit(full_duplex_ok, 1'b1, "above threshold");
    end
    set_in(8'h00, 8'hC4, 1'b1);
    cfg3({2'b00, 2'b00, 8'h00, 1'b0, 3'b110});
    chk_bit(full_duplex_ok, 1'b0, "zero noise code");
    cfg3({2'b00, 2'b01, 8'h00, 1'b0, 3'b110});
    chk_bit(full_duplex_ok, 1'b1, "quiet uses estimate");
    set_in(8'h00, 8'hC4, 1'b0);
    chk_bit(full_duplex_ok, 1'b0, "estimate refuses");
    set_in(8'h19, 8'h00, 1'b0);
    chk_bit(full_duplex_ok, 1'b1, "noisy uses erle");
  endtask

  task automatic t_speech();
    chk_bit(rx_suppress, 1'b1, "idle suppresses");
    @(posedge clk);
    rx_pwr <= 8'h40;
    tx_pwr <= 8'h40;
    repeat (2) @(posedge clk);
    #1;
    chk_bit(rx_suppress, 1'b0, "far speech releases");
    chk_bit(tx_speech, 1'b0, "no flag in full duplex");
    set_in(8'h00, 8'h00, 1'b0);
    chk_bit(tx_speech, 1'b1, "near speech half duplex");
    for (n = 0; n < 400 && rx_suppress !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    // Twenty 3 dB steps of two base periods each, six cycles already spent.
    chk_rng(n, 298, 330, "noise ramp time");
    chk_bit(tx_speech, 1'b0, "tx floor reached");
    @(posedge clk);
    rx_pwr <= 8'h00;
    @(posedge clk);
    rx_pwr <= 8'h40;
    repeat (2) @(posedge clk);
    #1;
    chk_bit(rx_suppress, 1'b0, "estimate fell fast");
    @(posedge clk);
    rx_pwr <= 8'h00;
    tx_pwr <= 8'h00;
  endtask

  task automatic t_howl();
    set_in(8'h20, 8'h00, 1'b0);
    cfg3({12'h000, 1'b1, 3'b110});
    chk_bit(full_duplex_ok, 1'b1, "duplex before howl");
    @(posedge clk);
    howl_trip <= 1'b1;
    @(posedge clk);
    howl_trip <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk_bit(full_duplex_ok, 1'b0, "held after howl");
    host.bus_rd(4'h1, d);
    chk_bit(d[7], 1'b1, "howl hold status");
    cfg3({12'h000, 1'b0, 3'b110});
    chk_bit(full_duplex_ok, 1'b1, "released by clear");
  endtask

  task automatic t_late();
    host.bus_wr(4'h0, `ESC_WORD_WARM);
    wait_rst(30, n);
    chk_rng(n, 0, 0, "late word no reset");
  endtask

  task automatic t_stale();
    boot_start();
    wait_clocks();
    wait_rst(TMR + 20, n);
    chk_bit(pc, 1'b1, "old warm word forgotten");
  endtask

  task automatic t_warm();
    cfg3({6'h00, 2'b01, 4'h0, 1'b0, 3'b110});
    boot_start();
    wait_clocks();
    host.bus_wr(4'h0, `ESC_WORD_WARM);
    wait_rst(TMR + 20, n);
    chk_bit(pw, 1'b1, "warm chosen");
    chk_bit(pcc, 1'b0, "coefficients kept");
    repeat (2) @(posedge clk);
    #1;
    chk_val({8'h00, tx_att_db}, 16'h0012, "defaults back");
  endtask

  task automatic t_early(input logic [15:0] w, input logic warm);
    boot_start();
    wait_clocks();
    host.bus_wr(4'h0, w);
    wait_rst(5, n);
    chk_rng(n, 1, 3, "early exit");
    chk_bit(pw, warm, "exit kind");
    chk_bit(pcc, ~warm, "exit clear");
  endtask

  task automatic complete_run();
    $display("Compares %0d, errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    complete_run();
  end

  initial begin
    sys_rst = 1'b1;
    {rx_pwr, tx_pwr, erle, noise} = 32'h0000_0000;
    asym_ok = 1'b0;
    howl_trip = 1'b0;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    t_defaults();
    t_cold();
    t_config();
    t_duplex();
    t_speech();
    t_howl();
    t_late();
    t_stale();
    t_warm();
    t_early(`ESC_WORD_COLD_X, 1'b0);
    t_early(`ESC_WORD_WARM_X, 1'b1);
    complete_run();
  end
endmodule

// >>> verilog/esc_defines.svh
// Constants for the echo-suppression configuration and reset sequencer.
// Assumes a 10 MHz system clock; included by every design file that needs them.
`ifndef ESC_DEFINES_SVH
`define ESC_DEFINES_SVH

// Register port addresses.
`define ESC_ADDR_MCR      4'h0
`define ESC_ADDR_STAT     4'h1
`define ESC_ADDR_CFG2     4'h2
`define ESC_ADDR_CFG3     4'h3

// Control word layout.
`define ESC_F_SEL         2:0
`define ESC_F_EXIT        15
`define ESC_SEL_NET       3'h4
`define ESC_SEL_ACU       3'h6
`define ESC_F_ACOUSTIC_RETURN_LOSS_THRESHOLD       15:14
`define ESC_F_ACOUSTIC_FULLDUPLEX_NOISE_THRESHOLD       13:12
`define ESC_F_TX_HALFDUPLEX_DETECT_THRESHOLD       11:10
`define ESC_F_TX_SUPPRESS_ATTENUATION       9:8
`define ESC_F_TX_SUPPRESS_BIAS      7:6
`define ESC_F_TX_SUPPRESS_THRESHOLD       5:4
`define ESC_F_HOLD_HALFDUPLEX_ON_HOWL       3
`define ESC_F_NOISE_ESTIMATOR_RAMP_RATE      7:6
`define ESC_F_RX_SUPPRESS_THRESHOLD       5:4
`define ESC_F_PATH_CHANGE_SENSITIVITY       3

// Reset values and special words.
`define ESC_MCR_RST       16'h0000
`define ESC_CFG2_RST      16'h0004
`define ESC_CFG3_RST      16'h0006
`define ESC_WORD_WARM     16'h7FFE
`define ESC_WORD_COLD_X   16'h8000
`define ESC_WORD_WARM_X   16'hFFFE

// Threshold figures in dB.
`define ESC_DB_24         8'h18
`define ESC_DB_18         8'h12
`define ESC_DB_30         8'h1E
`define ESC_DB_5          8'h05
`define ESC_DB_3          8'h03
`define ESC_DB_6          8'h06
`define ESC_DB_12         8'h0C
`define ESC_DB_15         8'h0F
`define ESC_DB_21         8'h15
`define ESC_DB_9          8'h09
`define ESC_NSE_M42       8'hD6
`define ESC_NSE_M54       8'hCA
`define ESC_RAMP_STEP_DB  8'h03

// Times and the clock period.
`define ESC_CLK_NS        100
`define ESC_OSC_MS        4
`define ESC_TIMER_MS      104
`define ESC_RAMP_BASE_MS  500
`define ESC_NS_PER_MS     1000000

`endif

// >>> verilog/esc_noise_track.sv
// Background noise power estimator with a selectable upward ramp rate.
// Assumes power levels in whole dB on an unsigned scale, sampled every cycle.
`timescale 1ns/1ns
`include "esc_defines.svh"
module esc_noise_track import esc_pkg::*; #(
  parameter logic [24:0] BASE_CYC = 25'd5000000
) (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       run,
  input  wire logic [7:0] cur_pwr,
  input  wire logic [1:0] ramp_sel,
  output logic [7:0]      est
);

  logic [7:0]  est_ff;
  logic [24:0] cnt_ff;
  logic [7:0]  nxt_est;
  logic [24:0] nxt_cnt;
  logic [24:0] period;
  logic [8:0]  stepped;

  always_comb begin
    case (ramp_sel)
      2'h1:    period = BASE_CYC;
      2'h2:    period = {BASE_CYC[22:0], 2'h0};
      default: period = {BASE_CYC[23:0], 1'b0};
    endcase
    stepped = {1'b0, est_ff} + {1'b0, `ESC_RAMP_STEP_DB};
    nxt_est = est_ff;
    nxt_cnt = cnt_ff + 25'h0000001;
    if (!run) begin
      nxt_est = 8'h00;
      nxt_cnt = 25'h0000000;
    end else if (cur_pwr <= est_ff) begin
      nxt_est = cur_pwr;
      nxt_cnt = 25'h0000000;
    end else if (cnt_ff >= period - 25'h0000001) begin
      nxt_cnt = 25'h0000000;
      nxt_est = (stepped > {1'b0, cur_pwr}) ? cur_pwr : stepped[7:0];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      est_ff <= 8'h00;
      cnt_ff <= 25'h0000000;
    end else begin
      est_ff <= nxt_est;
      cnt_ff <= nxt_cnt;
    end
  end

  assign est = est_ff;

endmodule

// >>> verilog/esc_pkg.sv
// Types shared by the echo-suppression configuration and reset sequencer.
// Assumes nothing beyond a SystemVerilog compiler.
package esc_pkg;

  typedef enum logic [2:0] {
    ST_DOWN,
    ST_OSC,
    ST_TIMER,
    ST_APPLY,
    ST_RUN
  } esc_state_e;

  typedef logic [15:0] esc_word_t;

endpackage

// >>> verilog/esc_reset_ctl.sv
// Configuration words and the hardware reset sequence of the echo canceller core.
// Assumes a 10 MHz clock; the reset pin and howl input come from outside the domain.
`timescale 1ns/1ns
`include "esc_defines.svh"
module esc_reset_ctl import esc_pkg::*; #(
  parameter int OSC_CYC   = `ESC_OSC_MS * `ESC_NS_PER_MS / `ESC_CLK_NS,
  parameter int TIMER_CYC = `ESC_TIMER_MS * `ESC_NS_PER_MS / `ESC_CLK_NS,
  parameter int RAMP_CYC  = `ESC_RAMP_BASE_MS * `ESC_NS_PER_MS / `ESC_CLK_NS
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        rst_pin_n,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [15:0]      reg_rdata,
  input  wire logic [7:0]  rx_pwr,
  input  wire logic [7:0]  tx_pwr,
  input  wire logic [7:0]  aec_erle_db,
  input  wire logic [7:0]  near_noise_db,
  input  wire logic        asym_ok,
  input  wire logic        howl_trip,
  output logic             osc_en,
  output logic             blocks_pwr_en,
  output logic             clocks_run,
  output logic             calib_start,
  output logic             cold_rst,
  output logic             warm_rst,
  output logic             coef_clear,
  output logic             full_duplex_ok,
  output logic             rx_suppress,
  output logic             tx_speech,
  output logic             path_sens_low,
  output logic [7:0]       tx_att_db,
  output logic [7:0]       tx_bias_db,
  output logic [7:0]       tx_thr_db
);

  // Picks one of three dB figures; the reserved code falls back to the reset figure.
  function automatic logic [7:0] pick_db(input logic [1:0] code, input logic [7:0] v0,
                                         input logic [7:0] v1, input logic [7:0] v2);
    case (code)
      2'h1:    pick_db = v1;
      2'h2:    pick_db = v2;
      default: pick_db = v0;
    endcase
  endfunction

  logic        pin_q;
  logic [7:0]  rx_noise;
  logic [7:0]  tx_noise;
  esc_state_e  state_ff;
  esc_state_e  nxt_state;
  logic [20:0] cnt_ff;
  logic [20:0] nxt_cnt;
  esc_word_t   mcr_ff;
  esc_word_t   nxt_mcr;
  esc_word_t   cfg2_ff;
  esc_word_t   nxt_cfg2;
  esc_word_t   cfg3_ff;
  esc_word_t   nxt_cfg3;
  logic        warm_sel;
  logic        wr_mcr;
  logic        cold_ff;
  logic        warm_ff;
  logic        calib_ff;
  logic        last_warm_ff;
  logic        nxt_last_warm;
  logic        howl_hold_ff;
  logic        nxt_howl_hold;
  logic        fd_ok_ff;
  logic        nxt_fd_ok;
  logic        rx_sup_ff;
  logic        nxt_rx_sup;
  logic        tx_sp_ff;
  logic        nxt_tx_sp;
  logic [7:0]  att_ff;
  logic [7:0]  bias_ff;
  logic [7:0]  thr_ff;
  logic [15:0] rdata_ff;
  logic [15:0] nxt_rdata;
  logic [7:0]  erle_thr;
  logic [8:0]  rx_need;
  logic [8:0]  tx_need;
  logic        use_erle;
  logic        howl_q;

  esc_sync2 u_pin_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .din     (rst_pin_n),
    .dout    (pin_q)
  );

  esc_sync2 u_howl_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .din     (howl_trip),
    .dout    (howl_q)
  );

  esc_noise_track #(.BASE_CYC(25'(RAMP_CYC))) u_rx_noise (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .run      (clocks_run),
    .cur_pwr  (rx_pwr),
    .ramp_sel (cfg2_ff[`ESC_F_NOISE_ESTIMATOR_RAMP_RATE]),
    .est      (rx_noise)
  );

  esc_noise_track #(.BASE_CYC(25'(RAMP_CYC))) u_tx_noise (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .run      (clocks_run),
    .cur_pwr  (tx_pwr),
    .ramp_sel (cfg2_ff[`ESC_F_NOISE_ESTIMATOR_RAMP_RATE]),
    .est      (tx_noise)
  );

  assign wr_mcr   = reg_wr && (reg_addr == `ESC_ADDR_MCR);
  assign warm_sel = (mcr_ff == `ESC_WORD_WARM) || (mcr_ff == `ESC_WORD_WARM_X);

  // Reset sequencer and control-word registers.
  always_comb begin
    nxt_state     = state_ff;
    nxt_cnt       = cnt_ff;
    nxt_mcr       = mcr_ff;
    nxt_cfg2      = cfg2_ff;
    nxt_cfg3      = cfg3_ff;
    nxt_last_warm = last_warm_ff;
    case (state_ff)
      ST_DOWN: begin
        nxt_cnt = 21'h000000;
        nxt_mcr = `ESC_MCR_RST;
        if (pin_q) begin
          nxt_state = ST_OSC;
        end
      end
      ST_OSC: begin
        nxt_cnt = cnt_ff + 21'h000001;
        if (cnt_ff == 21'(OSC_CYC - 1)) begin
          nxt_state = ST_TIMER;
        end
      end
      ST_TIMER: begin
        nxt_cnt = cnt_ff + 21'h000001;
        if (wr_mcr) begin
          nxt_mcr = reg_wdata;
        end
        if ((wr_mcr && reg_wdata[`ESC_F_EXIT]) || (cnt_ff == 21'(TIMER_CYC - 1))) begin
          nxt_state = ST_APPLY;
        end
      end
      ST_APPLY: begin
        nxt_last_warm = warm_sel;
        nxt_mcr       = `ESC_MCR_RST;
        nxt_cfg2      = `ESC_CFG2_RST;
        nxt_cfg3      = `ESC_CFG3_RST;
        nxt_state     = ST_RUN;
      end
      ST_RUN: begin
        if (wr_mcr) begin
          nxt_mcr = reg_wdata;
          if (reg_wdata[`ESC_F_SEL] == `ESC_SEL_ACU) begin
            nxt_cfg3 = reg_wdata;
          end else if (reg_wdata[`ESC_F_SEL] == `ESC_SEL_NET) begin
            nxt_cfg2 = reg_wdata;
          end
        end
      end
      default: begin
        nxt_state = ST_DOWN;
      end
    endcase
    if (!pin_q) begin
      nxt_state = ST_DOWN;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff     <= ST_DOWN;
      cnt_ff       <= 21'h000000;
      mcr_ff       <= `ESC_MCR_RST;
      cfg2_ff      <= `ESC_CFG2_RST;
      cfg3_ff      <= `ESC_CFG3_RST;
      last_warm_ff <= 1'b0;
      cold_ff      <= 1'b0;
      warm_ff      <= 1'b0;
      calib_ff     <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      cnt_ff       <= nxt_cnt;
      mcr_ff       <= nxt_mcr;
      cfg2_ff      <= nxt_cfg2;
      cfg3_ff      <= nxt_cfg3;
      last_warm_ff <= nxt_last_warm;
      cold_ff      <= (state_ff == ST_APPLY) && !warm_sel;
      warm_ff      <= (state_ff == ST_APPLY) && warm_sel;
      calib_ff     <= (state_ff == ST_OSC) && (nxt_state == ST_TIMER);
    end
  end

  // Duplex decisions and decoded thresholds.
  always_comb begin
    erle_thr   = pick_db(cfg3_ff[`ESC_F_ACOUSTIC_RETURN_LOSS_THRESHOLD], `ESC_DB_24, `ESC_DB_18, `ESC_DB_30);
    // Noise gate on the return-loss test.
    case (cfg3_ff[`ESC_F_ACOUSTIC_FULLDUPLEX_NOISE_THRESHOLD])
      2'h1:    use_erle = $signed(near_noise_db) > $signed(`ESC_NSE_M42);
      2'h2:    use_erle = $signed(near_noise_db) > $signed(`ESC_NSE_M54);
      default: use_erle = 1'b1;
    endcase
    nxt_fd_ok  = (use_erle ? (aec_erle_db > erle_thr) : asym_ok) && !nxt_howl_hold;
    rx_need    = {1'b0, rx_noise} +
                 {1'b0, pick_db(cfg2_ff[`ESC_F_RX_SUPPRESS_THRESHOLD], `ESC_DB_5, `ESC_DB_3, `ESC_DB_6)};
    nxt_rx_sup = !({1'b0, rx_pwr} > rx_need);
    tx_need    = {1'b0, tx_noise} +
                 {1'b0, pick_db(cfg3_ff[`ESC_F_TX_HALFDUPLEX_DETECT_THRESHOLD], `ESC_DB_5, `ESC_DB_3, `ESC_DB_6)};
    nxt_tx_sp  = !fd_ok_ff && ({1'b0, tx_pwr} > tx_need);
  end

  assign nxt_howl_hold = cfg3_ff[`ESC_F_HOLD_HALFDUPLEX_ON_HOWL] && (howl_hold_ff || howl_q);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      howl_hold_ff <= 1'b0;
      fd_ok_ff     <= 1'b0;
      rx_sup_ff    <= 1'b1;
      tx_sp_ff     <= 1'b0;
      att_ff       <= `ESC_DB_18;
      bias_ff      <= `ESC_DB_18;
      thr_ff       <= `ESC_DB_15;
    end else begin
      howl_hold_ff <= nxt_howl_hold;
      fd_ok_ff     <= nxt_fd_ok && (state_ff == ST_RUN);
      rx_sup_ff    <= nxt_rx_sup;
      tx_sp_ff     <= nxt_tx_sp;
      att_ff  <= pick_db(cfg3_ff[`ESC_F_TX_SUPPRESS_ATTENUATION], `ESC_DB_18, `ESC_DB_12, `ESC_DB_24);
      bias_ff <= pick_db(cfg3_ff[`ESC_F_TX_SUPPRESS_BIAS], `ESC_DB_18, `ESC_DB_15, `ESC_DB_21);
      thr_ff  <= pick_db(cfg3_ff[`ESC_F_TX_SUPPRESS_THRESHOLD], `ESC_DB_15, `ESC_DB_12, `ESC_DB_9);
    end
  end

  // Register read port; unmapped addresses read zero.
  always_comb begin
    nxt_rdata = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        `ESC_ADDR_MCR:  nxt_rdata = mcr_ff;
        `ESC_ADDR_STAT: nxt_rdata = {8'h00, howl_hold_ff, tx_sp_ff, rx_sup_ff, fd_ok_ff,
                                     last_warm_ff, state_ff == ST_TIMER, clocks_run, osc_en};
        `ESC_ADDR_CFG2: nxt_rdata = cfg2_ff;
        `ESC_ADDR_CFG3: nxt_rdata = cfg3_ff;
        default:        nxt_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_ff <= 16'h0000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata      = rdata_ff;
  assign osc_en         = (state_ff != ST_DOWN);
  assign blocks_pwr_en  = (state_ff != ST_DOWN);
  assign clocks_run     = (state_ff == ST_TIMER) || (state_ff == ST_APPLY) ||
                          (state_ff == ST_RUN);
  assign calib_start    = calib_ff;
  assign cold_rst       = cold_ff;
  assign warm_rst       = warm_ff;
  assign coef_clear     = cold_ff;
  assign full_duplex_ok = fd_ok_ff;
  assign rx_suppress    = rx_sup_ff;
  assign tx_speech      = tx_sp_ff;
  assign path_sens_low  = cfg2_ff[`ESC_F_PATH_CHANGE_SENSITIVITY];
  assign tx_att_db      = att_ff;
  assign tx_bias_db     = bias_ff;
  assign tx_thr_db      = thr_ff;

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  pin_down_a: assert property (!pin_q |=> !osc_en && !clocks_run)
    else $error("oscillator still enabled with reset pin low");
  osc_delay_a: assert property ($rose(clocks_run) |->
    $past(cnt_ff) == 21'(OSC_CYC - 1))
    else $error("clocks started at wrong delay");
  timer_end_a: assert property (state_ff == ST_TIMER && pin_q &&
    cnt_ff == 21'(TIMER_CYC - 1) |=> state_ff == ST_APPLY)
    else $error("timer expiry did not apply reset");
  restore_mcr_a: assert property (state_ff == ST_APPLY && pin_q |=>
    mcr_ff == `ESC_MCR_RST)
    else $error("mode word not restored");
  fresh_word_a: assert property (state_ff == ST_DOWN |=> mcr_ff == `ESC_MCR_RST)
    else $error("mode word survived power down");
  cold_default_a: assert property (state_ff == ST_APPLY && !warm_sel |=>
    cold_rst && coef_clear && !warm_rst)
    else $error("cold reset not taken");
  warm_keep_a: assert property (state_ff == ST_APPLY && warm_sel |=>
    warm_rst && !coef_clear)
    else $error("warm reset cleared coefficients");
  early_exit_a: assert property (state_ff == ST_TIMER && pin_q && wr_mcr &&
    reg_wdata[`ESC_F_EXIT] |=> state_ff == ST_APPLY ##1 (state_ff == ST_RUN || !pin_q))
    else $error("exit word did not end timer");
  late_word_a: assert property (state_ff == ST_RUN && pin_q && wr_mcr |=>
    state_ff == ST_RUN)
    else $error("late word restarted reset");
  acu_select_a: assert property (state_ff == ST_RUN && pin_q && wr_mcr &&
    reg_wdata[`ESC_F_SEL] == `ESC_SEL_ACU |=> cfg3_ff == $past(reg_wdata))
    else $error("acoustic word not loaded");
  howl_hold_a: assert property (howl_hold_ff && cfg3_ff[`ESC_F_HOLD_HALFDUPLEX_ON_HOWL] |->
    !full_duplex_ok)
    else $error("full duplex while held on howl");

  warm_path_c: cover property (state_ff == ST_APPLY && warm_sel);
  cold_exit_c: cover property (state_ff == ST_TIMER && wr_mcr && reg_wdata == `ESC_WORD_COLD_X);
  timer_run_c: cover property (state_ff == ST_TIMER && cnt_ff == 21'(TIMER_CYC - 1));

endmodule

// >>> verilog/esc_sync2.sv
// Two-flop synchroniser for a level arriving from outside the clock domain.
// Assumes the input is a slow level; the first flop feeds only the second.
`timescale 1ns/1ns
module esc_sync2 (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic din,
  output logic      dout
);

  logic meta_ff;
  logic sync_ff;
  logic nxt_meta;
  logic nxt_sync;

  always_comb begin
    nxt_meta = din;
    nxt_sync = meta_ff;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign dout = sync_ff;

endmodule
